// >>> logic/rpsm_pkg.sv
package rpsm_pkg;

  // Matrix dimensions
  localparam int NUM_IN   = 35;
  localparam int NUM_IO   = 25;
  localparam int NUM_PIN  = 26;
  localparam int SEL_W    = 6;
  localparam int IDX_W    = 5;
  localparam int DATA_W   = 16;
  localparam int FN_LAST  = 27;

  // Route register field layout
  localparam int FLD_LO_POS = 0;
  localparam int FLD_HI_POS = 8;

  // Reset values and selector limits
  localparam logic [SEL_W-1:0] IN_SEL_RST  = 6'h3F;
  localparam logic [SEL_W-1:0] OUT_SEL_RST = 6'h00;
  localparam logic [SEL_W-1:0] FN_NULL     = 6'h00;
  localparam logic [SEL_W-1:0] FN_MAX      = 6'h1B;
  localparam logic [SEL_W-1:0] PIN_LIMIT   = 6'h1A;

  // Pin 25 is input only; 4 and 12 are absent on this variant
  localparam logic [NUM_PIN-1:0] PIN_IN_IMPL = 26'h3FFEFEF;
  localparam logic [NUM_IO-1:0]  PIN_IO_IMPL = 25'h1FFEFEF;

  // Input functions, in selector storage order
  typedef enum int {
    IN_MOD_SIGNAL, IN_MOD_CARRIER1, IN_MOD_CARRIER2, IN_EXT_IRQ1, IN_EXT_IRQ2,
    IN_EXT_IRQ3, IN_EXT_IRQ4, IN_CAPTURE1, IN_CAPTURE2, IN_CAPTURE3,
    IN_CAPTURE4, IN_CAPTURE5, IN_CAPTURE6, IN_CMP_FAULT_A, IN_CMP_FAULT_B,
    IN_CMP_TRIG1, IN_CMP_TRIG2, IN_SPI1_CLK, IN_SPI1_DATA, IN_SPI1_SELECT,
    IN_SPI2_CLK, IN_SPI2_DATA, IN_SPI2_SELECT, IN_SPI3_CLK, IN_SPI3_DATA,
    IN_SPI3_SELECT, IN_TIMER_CLK, IN_UART1_CTS, IN_UART1_RX, IN_UART2_CTS,
    IN_UART2_RX, IN_UART3_CTS, IN_UART3_RX, IN_UART4_CTS, IN_UART4_RX
  } rpsm_in_fn_t;

  // Input route register index and field half for each function
  localparam logic [IDX_W-1:0] IN_REG [NUM_IN] = '{
    5'h1E, 5'h1F, 5'h1F, 5'h00, 5'h01, 5'h01, 5'h02, 5'h07, 5'h07, 5'h08,
    5'h08, 5'h09, 5'h09, 5'h0B, 5'h0B, 5'h00, 5'h02, 5'h14, 5'h14, 5'h15,
    5'h16, 5'h16, 5'h17, 5'h1C, 5'h1C, 5'h1D, 5'h17, 5'h12, 5'h12, 5'h13,
    5'h13, 5'h15, 5'h11, 5'h1B, 5'h1B};
  localparam logic IN_HI [NUM_IN] = '{
    1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
    1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
    1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1,
    1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  // Output function codes
  typedef enum logic [SEL_W-1:0] {
    FN_CMP1 = 6'h01, FN_CMP2 = 6'h02, FN_UART1_TX = 6'h03, FN_UART1_RTS = 6'h04,
    FN_UART2_TX = 6'h05, FN_UART2_RTS = 6'h06, FN_SPI1_DATA = 6'h07,
    FN_SPI1_CLK = 6'h08, FN_SPI1_SEL = 6'h09, FN_SPI2_DATA = 6'h0A,
    FN_SPI2_CLK = 6'h0B, FN_SPI2_SEL = 6'h0C, FN_CMPU1 = 6'h0D,
    FN_CMPU6 = 6'h12, FN_UART3_TX = 6'h13, FN_UART3_RTS = 6'h14,
    FN_UART4_TX = 6'h15, FN_UART4_RTS = 6'h16, FN_SPI3_DATA = 6'h17,
    FN_SPI3_CLK = 6'h18, FN_SPI3_SEL = 6'h19, FN_CMP3 = 6'h1A, FN_MOD = 6'h1B
  } rpsm_out_fn_t;

  // Peripheral outputs; bit position equals function code
  typedef struct packed {
    logic       modulator_out;
    logic       comparator_three_out;
    logic       spi_three_select_out;
    logic       spi_three_clock_out;
    logic       spi_three_data_out;
    logic       uart_four_rts;
    logic       uart_four_transmit;
    logic       uart_three_rts;
    logic       uart_three_transmit;
    logic [5:0] compare_unit_out;
    logic       spi_two_select_out;
    logic       spi_two_clock_out;
    logic       spi_two_data_out;
    logic       spi_one_select_out;
    logic       spi_one_clock_out;
    logic       spi_one_data_out;
    logic       uart_two_rts;
    logic       uart_two_transmit;
    logic       uart_one_request_to_send;
    logic       uart_one_transmit;
    logic       comparator_two_out;
    logic       comparator_one_out;
    logic       null_slot;
  } rpsm_periph_out_t;

  // Route register write request
  typedef struct packed {
    logic              en;
    logic              is_out;
    logic [IDX_W-1:0]  index;
    logic [DATA_W-1:0] data;
  } rpsm_wr_t;

  // Pad-side request from fixed logic for one pin
  typedef struct packed {
    logic ded_oe;
    logic ded_out;
    logic port_oe;
    logic port_out;
  } rpsm_pad_req_t;

endpackage : rpsm_pkg

// >>> logic/rpsm_in_mux.sv
`timescale 1ns/1ps
module rpsm_in_mux
  import rpsm_pkg::*;
(
  // Clocking
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               ce,
  // Selection
  input  wire logic [SEL_W-1:0]   sel,
  input  wire logic [NUM_PIN-1:0] pin_in,
  input  wire logic [NUM_PIN-1:0] pin_analog,
  // Result
  output logic                    fn_in,
  output logic                    mapped
);

  logic valid;
  logic fn_in_d;
  logic mapped_d;

  // One selector per input: no two pins can ever reach it
  always_comb begin
    valid    = (sel < PIN_LIMIT) && PIN_IN_IMPL[sel[4:0]];
    valid    = valid && !pin_analog[sel[4:0]];
    mapped_d = valid;
    fn_in_d  = valid ? pin_in[sel[4:0]] : 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fn_in  <= 1'b0;
      mapped <= 1'b0;
    end else if (ce) begin
      fn_in  <= fn_in_d;
      mapped <= mapped_d;
    end
  end

endmodule : rpsm_in_mux

// >>> logic/rpsm_out_mux.sv
`timescale 1ns/1ps
module rpsm_out_mux
  import rpsm_pkg::*;
(
  // Clocking
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             ce,
  // Selection
  input  wire logic [SEL_W-1:0] sel,
  input  wire logic [FN_LAST:0] periph,
  input  wire rpsm_pad_req_t    req,
  // Pad drive
  output logic                  pad_out,
  output logic                  pad_oe
);

  logic active;
  logic pad_out_d;
  logic pad_oe_d;

  // One selector per pin: only one function can ever drive it
  always_comb begin
    active = (sel != FN_NULL) && (sel <= FN_MAX);
    if (req.ded_oe) begin
      pad_out_d = req.ded_out;
      pad_oe_d  = 1'b1;
    end else if (active) begin
      pad_out_d = periph[sel[4:0]];
      pad_oe_d  = 1'b1;
    end else begin
      pad_out_d = req.port_out;
      pad_oe_d  = req.port_oe;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else if (ce) begin
      pad_out <= pad_out_d;
      pad_oe  <= pad_oe_d;
    end
  end

endmodule : rpsm_out_mux

// >>> logic/rpsm_matrix.sv
`timescale 1ns/1ps
module rpsm_matrix
  import rpsm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               CLK,
  input  wire logic               RESET_N,
  input  wire logic               CE,
  // Route register access
  input  wire rpsm_wr_t           WR,
  input  wire logic               REMAP_WRITE_LOCK,
  input  wire logic               RD_IS_OUT,
  input  wire logic [IDX_W-1:0]   RD_INDEX,
  output logic [DATA_W-1:0]       RD_DATA,
  // Pads
  input  wire logic [NUM_PIN-1:0] PAD_IN,
  input  wire logic [NUM_PIN-1:0] PAD_ANALOG,
  input  wire rpsm_pad_req_t [NUM_IO-1:0] PAD_REQ,
  output logic [NUM_IO-1:0]       PAD_OUT,
  output logic [NUM_IO-1:0]       PAD_OE,
  // Peripherals
  input  wire rpsm_periph_out_t   PERIPH_OUT,
  output logic [NUM_IN-1:0]       PERIPH_IN,
  output logic [NUM_IN-1:0]       PERIPH_IN_MAPPED
);

  logic [SEL_W-1:0]  in_sel_q  [NUM_IN];
  logic [SEL_W-1:0]  in_sel_d  [NUM_IN];
  logic [SEL_W-1:0]  out_sel_q [NUM_IO];
  logic [SEL_W-1:0]  out_sel_d [NUM_IO];
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic              wr_ok;
  logic [SEL_W-1:0]  wr_lo;
  logic [SEL_W-1:0]  wr_hi;
  logic [FN_LAST:0]  periph_vec;

  // Field position in the packed struct is the function code
  assign periph_vec = FN_LAST'(0) | PERIPH_OUT;

  // Lock check happens here so a locked write looks accepted but stores nothing
  assign wr_ok = WR.en && !REMAP_WRITE_LOCK;
  assign wr_lo = WR.data[FLD_LO_POS +: SEL_W];
  assign wr_hi = WR.data[FLD_HI_POS +: SEL_W];

  // Input selectors, stored per peripheral function
  always_comb begin
    for (int f = 0; f < NUM_IN; f++) begin
      in_sel_d[f] = in_sel_q[f];
      if (wr_ok && !WR.is_out && (WR.index == IN_REG[f])) begin
        in_sel_d[f] = IN_HI[f] ? wr_hi : wr_lo;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int f = 0; f < NUM_IN; f++) begin
        in_sel_q[f] <= IN_SEL_RST;
      end
    end else if (CE) begin
      in_sel_q <= in_sel_d;
    end
  end

  // Output selectors, stored per pin; absent pins never load
  always_comb begin
    for (int p = 0; p < NUM_IO; p++) begin
      out_sel_d[p] = out_sel_q[p];
      if (wr_ok && WR.is_out && PIN_IO_IMPL[p] && (WR.index == IDX_W'(p / 2))) begin
        out_sel_d[p] = (p % 2 == 1) ? wr_hi : wr_lo;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < NUM_IO; p++) begin
        out_sel_q[p] <= OUT_SEL_RST;
      end
    end else if (CE) begin
      out_sel_q <= out_sel_d;
    end
  end

  // Readback of the route registers; unused fields read zero
  always_comb begin
    rd_data_d = '0;
    if (RD_IS_OUT) begin
      for (int p = 0; p < NUM_IO; p++) begin
        if (RD_INDEX == IDX_W'(p / 2)) begin
          if (p % 2 == 1) begin
            rd_data_d[FLD_HI_POS +: SEL_W] = out_sel_q[p];
          end else begin
            rd_data_d[FLD_LO_POS +: SEL_W] = out_sel_q[p];
          end
        end
      end
    end else begin
      for (int f = 0; f < NUM_IN; f++) begin
        if (RD_INDEX == IN_REG[f]) begin
          if (IN_HI[f]) begin
            rd_data_d[FLD_HI_POS +: SEL_W] = in_sel_q[f];
          end else begin
            rd_data_d[FLD_LO_POS +: SEL_W] = in_sel_q[f];
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_data_q <= '0;
    end else if (CE) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign RD_DATA = rd_data_q;

  // Every input sees all pins, so one pin may feed many functions
  for (genvar f = 0; f < NUM_IN; f++) begin : g_in
    rpsm_in_mux u_in (
      .clk        (CLK),
      .reset_n    (RESET_N),
      .ce         (CE),
      .sel        (in_sel_q[f]),
      .pin_in     (PAD_IN),
      .pin_analog (PAD_ANALOG),
      .fn_in      (PERIPH_IN[f]),
      .mapped     (PERIPH_IN_MAPPED[f])
    );
  end

  // Every pin sees all functions, so one function may drive many pins
  for (genvar p = 0; p < NUM_IO; p++) begin : g_out
    rpsm_out_mux u_out (
      .clk     (CLK),
      .reset_n (RESET_N),
      .ce      (CE),
      .sel     (out_sel_q[p]),
      .periph  (periph_vec),
      .req     (PAD_REQ[p]),
      .pad_out (PAD_OUT[p]),
      .pad_oe  (PAD_OE[p])
    );
  end

endmodule : rpsm_matrix

// >>> verification/rpsm_matrix_asserts.sv
`timescale 1ns/1ps
module rpsm_matrix_asserts
  import rpsm_pkg::*;
(
  // Clock and control
  input wire logic                       CLK,
  input wire logic                       RESET_N,
  input wire logic                       CE,
  input wire rpsm_wr_t                   WR,
  input wire logic                       REMAP_WRITE_LOCK,
  // Readback
  input wire logic                       RD_IS_OUT,
  input wire logic [IDX_W-1:0]           RD_INDEX,
  input wire logic [DATA_W-1:0]          RD_DATA,
  // Pads and peripherals
  input wire logic [NUM_PIN-1:0]         PAD_ANALOG,
  input wire rpsm_pad_req_t [NUM_IO-1:0] PAD_REQ,
  input wire logic [NUM_IO-1:0]          PAD_OUT,
  input wire logic [NUM_IO-1:0]          PAD_OE,
  input wire logic [NUM_IN-1:0]          PERIPH_IN,
  input wire logic [NUM_IN-1:0]          PERIPH_IN_MAPPED
);
  logic [1:0] wrote_q;
  logic [1:0] wrote_d;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Any accepted write since reset, per bank; conservative for bad indexes
  always_comb begin
    wrote_d = wrote_q;
    if (CE && WR.en && !REMAP_WRITE_LOCK) wrote_d[WR.is_out] = 1'b1;
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) wrote_q <= 2'h0;
    else wrote_q <= wrote_d;
  end

  AST_RSVD: assert property (RD_DATA[15:14] == 2'h0 && RD_DATA[7:6] == 2'h0)
    else $error("readback bits outside the fields");
  AST_LOCK: assert property (
    CE && $past(CE) && $past(RESET_N) && $stable(RD_INDEX) && $stable(RD_IS_OUT)
    && ($past(REMAP_WRITE_LOCK) || !$past(WR.en)) |=> $stable(RD_DATA))
    else $error("selector changed without an accepted write");
  AST_UNMAP: assert property ((PERIPH_IN & ~PERIPH_IN_MAPPED) == '0)
    else $error("unmapped input not grounded");
  AST_INRST: assert property (!wrote_q[0] |-> PERIPH_IN_MAPPED == '0)
    else $error("input mapped with reset selectors");
  AST_ANALOG: assert property (CE && &PAD_ANALOG |=> PERIPH_IN_MAPPED == '0)
    else $error("input mapped from an analog pin");
  AST_SELRST: assert property (
    CE && !wrote_q[0] && !RD_IS_OUT && (RD_INDEX == 5'h17 || RD_INDEX == 5'h0B)
    |=> RD_DATA == 16'h3F3F)
    else $error("input selector pair not at reset value");
  for (genvar i = 0; i < NUM_IO; i++) begin : g_pin
    AST_DED: assert property (
      CE && PIN_IO_IMPL[i] && PAD_REQ[i].ded_oe
      |=> PAD_OE[i] && PAD_OUT[i] == $past(PAD_REQ[i].ded_out))
      else $error("dedicated output lost the pin");
    AST_NULL: assert property (
      CE && PIN_IO_IMPL[i] && !wrote_q[1] && !PAD_REQ[i].ded_oe
      |=> PAD_OE[i] == $past(PAD_REQ[i].port_oe) && PAD_OUT[i] == $past(PAD_REQ[i].port_out))
      else $error("reset pin not left to port logic");
  end
endmodule : rpsm_matrix_asserts

bind rpsm_matrix rpsm_matrix_asserts u_asserts (.CLK, .RESET_N, .CE, .WR, .REMAP_WRITE_LOCK,
  .RD_IS_OUT, .RD_INDEX, .RD_DATA, .PAD_ANALOG, .PAD_REQ, .PAD_OUT, .PAD_OE, .PERIPH_IN,
  .PERIPH_IN_MAPPED);

// >>> verification/rpsm_periph_model.sv
`timescale 1ns/1ps
module rpsm_periph_model
  import rpsm_pkg::*;
(
  // Control
  input  wire logic          pat,
  // Peripheral and pad levels
  output rpsm_periph_out_t   periph_out,
  output logic [NUM_PIN-1:0] pad_in
);
  // Irregular patterns and their inverse expose swapped or stuck routes
  assign periph_out = pat ? ~28'h6C3A9E5 : 28'h6C3A9E5;
  assign pad_in     = pat ? ~26'h2C5B34D : 26'h2C5B34D;
endmodule : rpsm_periph_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import rpsm_pkg::*;
;
  logic                       clk, reset_n, ce, lock, rio, pat;
  logic [IDX_W-1:0]           ridx;
  rpsm_wr_t                   wr_r;
  logic [DATA_W-1:0]          rdat;
  logic [NUM_PIN-1:0]         pad_an, pad_in;
  rpsm_pad_req_t [NUM_IO-1:0] req;
  logic [NUM_IO-1:0]          pout, poe;
  rpsm_periph_out_t           po;
  logic [NUM_IN-1:0]          pin, pmap;
  int                         errors, checked;

  rpsm_matrix u_dut (.CLK(clk), .RESET_N(reset_n), .CE(ce), .WR(wr_r), .REMAP_WRITE_LOCK(lock),
    .RD_IS_OUT(rio), .RD_INDEX(ridx), .RD_DATA(rdat), .PAD_IN(pad_in), .PAD_ANALOG(pad_an),
    .PAD_REQ(req), .PAD_OUT(pout), .PAD_OE(poe), .PERIPH_OUT(po), .PERIPH_IN(pin),
    .PERIPH_IN_MAPPED(pmap));
  rpsm_periph_model u_model (.pat(pat), .periph_out(po), .pad_in(pad_in));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("checks=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic o, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
    @(posedge clk) wr_r <= '{1'b1, o, i, d};
    @(posedge clk) wr_r.en <= 1'b0;
  endtask : wr

  task automatic rd(input logic o, input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] e);
    @(posedge clk) {rio, ridx} <= {o, i};
    @(posedge clk);
    @(negedge clk) chk(rdat, e);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_reset;
    logic [DATA_W-1:0] e;
    for (int i = 0; i < 32; i++) begin
      e = '0;
      for (int f = 0; f < NUM_IN; f++)
        if (IN_REG[f] == i) e |= IN_HI[f] ? 16'h3F00 : 16'h003F;
      rd(1'b0, i[4:0], e);
      rd(1'b1, i[4:0], '0);
    end
  endtask : t_reset

  task automatic t_out;
    logic [5:0]  c;
    logic        v;
    logic [27:0] p;
    for (int i = 0; i < 64; i++) begin
      c = i[5:0];
      v = c != FN_NULL && c <= FN_MAX;
      wr(1'b1, '0, {2'h0, c, 2'h0, c});
      for (int k = 0; k < 2; k++) begin
        @(posedge clk) pat <= k[0];
        settle;
        p = po;
        chk({poe[1:0], pout[1:0]}, {1'b1, v, v ? p[c[4:0]] : 1'b1, v & p[c[4:0]]});
      end
      rd(1'b1, '0, {2'h0, c, 2'h0, c});
    end
  endtask : t_out

  task automatic t_misc;
    @(posedge clk) lock <= 1'b1;
    wr(1'b1, '0, 16'h0101);
    rd(1'b1, '0, 16'h3F3F);
    @(posedge clk) {lock, pat, req[2]} <= {1'b0, 1'b0, 4'h8};
    wr(1'b1, 5'h01, 16'h0007);
    settle;
    chk({poe[2], pout[2]}, 2'b10);
    wr(1'b1, 5'h02, 16'h0707);
    rd(1'b1, 5'h02, 16'h0700);
    chk(poe[5:4], 2'b10);
    wr(1'b1, 5'h0C, 16'h0707);
    rd(1'b1, 5'h0C, 16'h0007);
  endtask : t_misc

  task automatic t_in;
    int   p;
    logic m;
    for (int i = 0; i < 32; i++) wr(1'b0, i[4:0], {2'h0, 6'(i + 3), 2'h0, i[5:0]});
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) pat <= k[0];
      settle;
      for (int f = 0; f < NUM_IN; f++) begin
        p = IN_HI[f] ? IN_REG[f] + 3 : IN_REG[f];
        m = p < NUM_PIN && PIN_IN_IMPL[p];
        chk({pmap[f], pin[f]}, {m, m & pad_in[p]});
      end
    end
    @(posedge clk) pad_an <= '1;
    settle;
    chk(pmap, '0);
  endtask : t_in

  // CE low must freeze readback and refuse writes; index 3 was never written
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    @(posedge clk) {rio, ridx} <= {1'b0, 5'h17};
    wr(1'b1, 5'h03, 16'h0101);
    @(negedge clk) chk(rdat, 16'h0007);
    @(posedge clk) ce <= 1'b1;
    rd(1'b1, 5'h03, 16'h0000);
  endtask : t_ce

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    {reset_n, ce, lock, rio, pat} = 5'h08;
    {ridx, wr_r, pad_an, req} = '0;
    req[1] = 4'h3;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_out;
    t_misc;
    t_in;
    t_ce;
    final_report;
  end

  initial begin
    #100us;
    errors++;
    final_report;
  end
endmodule : testbench
